/* File: hdl/wrf_pkg.sv */
// constants for the watchdog timer and reset-cause flags block
package wrf_pkg;
   // register indices on the byte-wide register port
   localparam int ADDR_W = 2;
   localparam logic [ADDR_W-1:0] A_STATUS = 2'h0;
   localparam logic [ADDR_W-1:0] A_CTRL = 2'h1;

   // control register bit positions
   localparam int B_TIF = 7;
   localparam int B_TIE = 6;
   localparam int B_P3 = 5;
   localparam int B_CE = 4;
   localparam int B_WEN = 3;
   localparam int B_P2 = 2;
   localparam int B_P0 = 0;

   // status register bit positions
   localparam int B_WDOG = 3;
   localparam int B_BOD = 2;
   localparam int B_PIN = 1;
   localparam int B_POR = 0;

   // timing
   localparam int OSC_KHZ = 128;
   localparam int CE_CYC = 4;
   localparam logic [2:0] CE_LOAD = 3'(CE_CYC - 1);
   localparam int CNT_W = 20;
   localparam logic [CNT_W-1:0] CNT_BASE = 20'h0_0800;
   localparam logic [CNT_W-1:0] CNT_ONE = 20'h0_0001;
   localparam logic [3:0] PER_MAX = 4'h9;
   localparam logic [3:0] PER_RST = 4'h0;
   localparam int DLY_W = 16;
   localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;

   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_PULSE = 4'h2,
      ST_HOLD = 4'h4,
      ST_DELAY = 4'h8
   } wrf_st_e;

   typedef struct packed {
      wrf_st_e st;
      logic [CNT_W-1:0] cnt;
      logic [DLY_W-1:0] dly;
      logic [3:0] per;
      logic [2:0] ce_cnt;
      logic ce;
      logic wen;
      logic tie;
      logic tif;
      logic wdog_flag;
      logic bod_flag;
      logic pin_flag;
      logic por_flag;
      logic [7:0] rdata;
      logic irq;
      logic wdt_pulse;
      logic core_rst_n;
   } wrf_state_s;
endpackage : wrf_pkg

/* File: hdl/wrf_top.sv */
// watchdog timer with change-enable protection and reset-cause flags
// Functional notes
// R01: watchdog counts ticks of its own 128 kHz oscillator, not core clocks.
// R02: count clears on restart instruction, on disable and on any chip reset.
// R03: expiry in reset mode resets the chip; core restarts from reset vector.
// R04: watchdog reset is a one-cycle pulse; start-up delay begins as it falls.
// R05: fuse picks level 1 (off, timed disable) or level 2 (always on).
// R06: interrupt flag sets on time-out in interrupt mode; clears on vector or write one.
// R07: interrupt runs only with global and watchdog interrupt enables both set; with enable set, the request is held after the time-out clears irq-enable.
// R08: enable/irq-enable pair selects stopped, interrupt, reset or interrupt then reset.
// R09: with enable set, a time-out clears irq-enable so the next one resets.
// R10: change-enable clears itself four cycles after being written one.
// R11: clearing enable is accepted only while change-enable is one.
// R12: software writes change-enable and enable as one, then enable zero within four.
// R13: at level 2, period changes are ignored without an open change window.
// R14: at level 2 the watchdog never disables and enable reads one.
// R15: at level 1 the watchdog-reset flag forces enable to one.
// R16: four-bit period on bits 5,2..0; codes 0..9 give 2048..1048576 ticks.
// R17: watchdog, brown-out, pin flags set by their source; clear by POR or write zero.
// R18: power-on flag set by POR; only a software zero write clears it.
// R19: brown-out asserts reset at once; release waits for the start-up delay.
// R20: software not using the watchdog clears its flag and enable at start.
// R21: level 2 period change: open window, then write period with change-enable low.
// R22: oscillator ticks and requests cross into the core clock without loss or repeat.
// R23: reserved period codes are not taken; the previous period stays in force.
`timescale 1ns/10ps
module wrf_top
   import wrf_pkg::*;
#(
   parameter logic [DLY_W-1:0] STARTUP_CYC = 16'h0040
) (
   // clock and power-on reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // watchdog oscillator tick, one core cycle per oscillator period
   input wire logic i_osc_tick,
   // fuse, high when programmed (safety level 2)
   input wire logic i_safety_level_fuse,
   // core events
   input wire logic i_restart_instruction,
   input wire logic i_irq_ack,
   input wire logic i_global_irq_en,
   // other reset sources
   input wire logic i_pin_rst,
   input wire logic i_bod_en,
   input wire logic i_bod_low,
   // register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // results
   output logic o_irq,
   output logic o_wdt_rst_pulse,
   output logic o_core_rst_n
);

   wrf_state_s s_r;
   wrf_state_s s_nxt;

   logic wen_eff;
   logic running;
   logic timeout;
   logic wr_ctrl;
   logic wr_stat;
   logic src_rst;
   logic [3:0] per_wr;
   logic [CNT_W-1:0] lim;

   // level 2 and a pending watchdog-reset flag both override the stored bit
   assign wen_eff = s_r.wen | i_safety_level_fuse | s_r.wdog_flag; // [R14] [R15] [R05]
   assign running = wen_eff | s_r.tie; // [R08]
   assign lim = (CNT_BASE << s_r.per) - CNT_ONE; // [R16]
   // the tick is a one-cycle pulse already in the core domain, so each
   // oscillator period advances the count exactly once
   assign timeout = running && i_osc_tick && (s_r.cnt == lim)
      && (s_r.st == ST_RUN); // [R01] [R22]
   assign wr_ctrl = i_wr && (i_addr == A_CTRL);
   assign wr_stat = i_wr && (i_addr == A_STATUS);
   assign src_rst = i_pin_rst || (i_bod_en && i_bod_low);
   assign per_wr = {i_wdata[B_P3], i_wdata[B_P2:B_P0]};

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = 8'h00;
      s_nxt.wdt_pulse = 1'b0;

      // change window closes by itself
      if (s_r.ce) begin
         if (s_r.ce_cnt == 3'h0) begin
            s_nxt.ce = 1'b0; // [R10]
         end else begin
            s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
         end
      end

      if (wr_ctrl) begin
         if (i_wdata[B_TIF]) begin
            s_nxt.tif = 1'b0; // [R06]
         end
         s_nxt.tie = i_wdata[B_TIE];
         if (i_wdata[B_WEN]) begin
            s_nxt.wen = 1'b1;
         end else if (s_r.ce && !i_safety_level_fuse) begin
            s_nxt.wen = 1'b0; // [R11] [R12] [R14]
         end
         // level 1 may retune freely; level 2 needs the window
         if ((per_wr <= PER_MAX) && (!i_safety_level_fuse || s_r.ce)) begin
            s_nxt.per = per_wr; // [R13] [R21] [R23] [R05]
         end
         if (i_wdata[B_CE] && i_wdata[B_WEN]) begin
            s_nxt.ce = 1'b1; // [R12] [R21]
            s_nxt.ce_cnt = CE_LOAD; // [R10]
         end
      end

      if (wr_stat) begin
         // a written one leaves a flag alone, a zero clears it
         s_nxt.wdog_flag = s_r.wdog_flag & i_wdata[B_WDOG]; // [R17] [R20]
         s_nxt.bod_flag = s_r.bod_flag & i_wdata[B_BOD]; // [R17]
         s_nxt.pin_flag = s_r.pin_flag & i_wdata[B_PIN]; // [R17]
         s_nxt.por_flag = s_r.por_flag & i_wdata[B_POR]; // [R18]
      end

      if (i_irq_ack) begin
         s_nxt.tif = 1'b0; // [R06]
      end

      // counter
      if (!running || i_restart_instruction) begin
         s_nxt.cnt = '0; // [R02]
      end else if (i_osc_tick) begin
         if (s_r.cnt == lim) begin
            s_nxt.cnt = '0;
         end else begin
            s_nxt.cnt = s_r.cnt + CNT_ONE; // [R01]
         end
      end

      // time-out action; hardware sets win over same-cycle clears
      if (timeout) begin
         if (s_r.tie) begin
            s_nxt.tif = 1'b1; // [R06] [R08]
            if (wen_eff) begin
               s_nxt.tie = 1'b0; // [R09]
            end
         end else begin
            s_nxt.wdt_pulse = 1'b1; // [R03] [R04]
            s_nxt.wdog_flag = 1'b1; // [R17]
         end
      end

      // reset sequencer
      case (s_r.st)
         ST_RUN: begin
            if (timeout && !s_r.tie) begin
               s_nxt.st = ST_PULSE; // [R03]
               s_nxt.core_rst_n = 1'b0;
            end
         end
         ST_PULSE: begin
            // delay counts from the falling edge of the one-cycle pulse
            s_nxt.st = ST_DELAY; // [R04]
            s_nxt.dly = '0;
         end
         ST_HOLD: begin
            if (!src_rst) begin
               s_nxt.st = ST_DELAY; // [R19]
               s_nxt.dly = '0;
            end
         end
         ST_DELAY: begin
            if (s_r.dly == STARTUP_CYC - DLY_ONE) begin
               s_nxt.st = ST_RUN; // [R19] [R04]
               s_nxt.core_rst_n = 1'b1;
            end else begin
               s_nxt.dly = s_r.dly + DLY_ONE;
            end
         end
         default: begin
            s_nxt.st = ST_DELAY;
            s_nxt.dly = '0;
         end
      endcase

      // external sources take over at once from any state
      if (src_rst) begin
         s_nxt.st = ST_HOLD; // [R19]
         s_nxt.core_rst_n = 1'b0;
         s_nxt.dly = '0;
         if (i_pin_rst) begin
            s_nxt.pin_flag = 1'b1; // [R17]
         end
         if (i_bod_en && i_bod_low) begin
            s_nxt.bod_flag = 1'b1; // [R17]
         end
      end

      // chip reset returns control to its initial state; reset-cause flags survive
      if (s_nxt.st != ST_RUN) begin
         s_nxt.cnt = '0; // [R02]
         s_nxt.wen = 1'b0;
         s_nxt.tie = 1'b0;
         s_nxt.tif = 1'b0;
         s_nxt.ce = 1'b0;
         s_nxt.ce_cnt = 3'h0;
         s_nxt.per = PER_RST;
      end

      if (i_rd) begin
         case (i_addr)
            A_STATUS: begin
               s_nxt.rdata[B_WDOG] = s_r.wdog_flag;
               s_nxt.rdata[B_BOD] = s_r.bod_flag;
               s_nxt.rdata[B_PIN] = s_r.pin_flag;
               s_nxt.rdata[B_POR] = s_r.por_flag;
            end
            A_CTRL: begin
               s_nxt.rdata[B_TIF] = s_r.tif;
               s_nxt.rdata[B_TIE] = s_r.tie;
               s_nxt.rdata[B_P3] = s_r.per[3];
               s_nxt.rdata[B_CE] = s_r.ce;
               s_nxt.rdata[B_WEN] = wen_eff; // [R14] [R15]
               s_nxt.rdata[B_P2:B_P0] = s_r.per[2:0];
            end
            default: begin
               s_nxt.rdata = 8'h00;
            end
         endcase
      end

      // with both enables set the time-out drops the irq enable, so the request
      // it raises is held until the flag clears, the global enable drops or the watchdog is disabled
      s_nxt.irq = s_nxt.tif && i_global_irq_en && (s_nxt.st == ST_RUN)
         && (s_nxt.tie || (wen_eff && ((timeout && s_r.tie) || s_r.irq))); // [R07] [R08]
   end

   // power-on reset: the only reset that presets the power-on flag
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_r.st <= ST_DELAY;
         s_r.cnt <= '0;
         s_r.dly <= '0;
         s_r.per <= PER_RST;
         s_r.ce_cnt <= 3'h0;
         s_r.ce <= 1'b0;
         s_r.wen <= 1'b0;
         s_r.tie <= 1'b0;
         s_r.tif <= 1'b0;
         s_r.wdog_flag <= 1'b0; // [R17]
         s_r.bod_flag <= 1'b0;
         s_r.pin_flag <= 1'b0;
         s_r.por_flag <= 1'b1; // [R18]
         s_r.rdata <= 8'h00;
         s_r.irq <= 1'b0;
         s_r.wdt_pulse <= 1'b0;
         s_r.core_rst_n <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rdata = s_r.rdata;
   assign o_irq = s_r.irq;
   assign o_wdt_rst_pulse = s_r.wdt_pulse;
   assign o_core_rst_n = s_r.core_rst_n;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   sequence ce_opened;
      $rose(s_r.ce);
   endsequence

   sequence wdt_fire;
      timeout && !s_r.tie;
   endsequence

   sequence pulse_then_delay;
      o_wdt_rst_pulse ##1 (!o_wdt_rst_pulse && !o_core_rst_n && s_r.st == ST_DELAY);
   endsequence

   sequence irq_both_timeout;
      timeout && s_r.tie && wen_eff && i_global_irq_en && !src_rst;
   endsequence

   sequence tif_cleared;
      (i_irq_ack || (wr_ctrl && i_wdata[B_TIF])) && !timeout;
   endsequence

   // a chip reset inside the window closes it early on purpose
   ce_window_a: assert property (ce_opened |-> (s_r.ce || !o_core_rst_n) [*4] // [R10]
      ##1 (!s_r.ce || $past(wr_ctrl)))
      else $error("change window length wrong");

   wdt_reset_a: assert property (wdt_fire |=> pulse_then_delay) // [R03] [R04]
      else $error("watchdog reset pulse sequence wrong");

   wdt_flag_a: assert property (wdt_fire |=> s_r.wdog_flag) // [R17]
      else $error("watchdog flag not set");

   restart_clr_a: assert property (i_restart_instruction && s_nxt.st == ST_RUN |=> s_r.cnt == '0) // [R02]
      else $error("restart did not clear count");

   stopped_a: assert property (!running |=> s_r.cnt == '0 && !o_wdt_rst_pulse) // [R08]
      else $error("stopped watchdog still active");

   irq_timeout_a: assert property (timeout && s_r.tie && wen_eff |=> s_r.tif && !s_r.tie) // [R09]
      else $error("irq enable not cleared on time-out");

   irq_gate_a: assert property (o_irq |-> $past(i_global_irq_en) && s_r.tif // [R07] [R08]
      && (s_r.tie || $past(wen_eff)))
      else $error("interrupt raised without enables");

   wen_clear_a: assert property ($fell(s_r.wen) && s_r.st == ST_RUN |-> $past(s_r.ce)) // [R11]
      else $error("enable cleared outside window");

   wen_read_a: assert property (i_rd && i_addr == A_CTRL && (i_safety_level_fuse || s_r.wdog_flag)
      |=> o_rdata[B_WEN]) // [R14] [R15]
      else $error("forced enable reads zero");

   bod_hold_a: assert property (i_bod_en && i_bod_low |=> !o_core_rst_n ##1 !o_core_rst_n) // [R19]
      else $error("brown-out did not hold reset");

   reserved_per_a: assert property (wr_ctrl && per_wr > PER_MAX && s_nxt.st == ST_RUN
      |=> $stable(s_r.per)) // [R23]
      else $error("reserved period code taken");

   lvl2_per_a: assert property (wr_ctrl && i_safety_level_fuse && !s_r.ce && s_nxt.st == ST_RUN
      |=> $stable(s_r.per)) // [R13]
      else $error("period changed outside window");

   por_keep_a: assert property (s_r.por_flag && !(wr_stat && !i_wdata[B_POR]) |=> s_r.por_flag) // [R18]
      else $error("power-on flag lost");

   both_irq_a: assert property (irq_both_timeout |=> o_irq) // [R08]
      else $error("no interrupt with both enables set");

   tif_clear_a: assert property (tif_cleared |=> !s_r.tif) // [R06]
      else $error("interrupt flag not cleared");

   src_reset_a: assert property (src_rst |=> !o_core_rst_n && s_r.st == ST_HOLD) // [R19]
      else $error("reset source not taken at once");

   pin_flag_a: assert property (i_pin_rst |=> s_r.pin_flag) // [R17]
      else $error("pin reset flag not set");

   rst_count_a: assert property (!o_core_rst_n |-> s_r.cnt == '0) // [R02]
      else $error("count not cleared in chip reset");

endmodule : wrf_top

/* File: dv/tb_wrf_top.sv */
// self-checking bench for the watchdog timer and reset-cause flags block
`timescale 1ns/10ps
module tb_wrf_top;
   import wrf_pkg::*;
   logic i_clk, i_rstn, i_osc_tick, i_safety_level_fuse, i_restart_instruction, i_irq_ack;
   logic i_global_irq_en, i_pin_rst, i_bod_en, i_bod_low, i_wr, i_rd;
   logic [ADDR_W-1:0] i_addr;
   logic [7:0] i_wdata, o_rdata, last;
   logic o_irq, o_wdt_rst_pulse, o_core_rst_n;
   int fails, num_checks, cyc, n_rst;

   // short start-up delay keeps each chip reset brief
   wrf_top #(.STARTUP_CYC(16'h0004)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_osc_tick(i_osc_tick), .i_safety_level_fuse(i_safety_level_fuse),
      .i_restart_instruction(i_restart_instruction), .i_irq_ack(i_irq_ack),
      .i_global_irq_en(i_global_irq_en), .i_pin_rst(i_pin_rst), .i_bod_en(i_bod_en),
      .i_bod_low(i_bod_low), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_irq(o_irq), .o_wdt_rst_pulse(o_wdt_rst_pulse),
      .o_core_rst_n(o_core_rst_n));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   // oscillator tick every other core cycle: 2048 ticks span 4096 cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      i_osc_tick <= ~i_osc_tick;
      if (o_wdt_rst_pulse === 1'b1) n_rst <= n_rst + 1;
      if (cyc == 80000) begin
         fails = fails + 1;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string nm);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(nm, exp, o_rdata);
   endtask : rd

   // sel 0 irq, 1 watchdog pulse, 2 core reset; bounded wait for a level
   task automatic wait_sig(input int sel, input logic val, input int lim, input string nm);
      logic s;
      num_checks++;
      for (int n = 0; n < lim; n++) begin
         @(posedge i_clk);
         #1;
         s = (sel == 0) ? o_irq : (sel == 1) ? o_wdt_rst_pulse : o_core_rst_n;
         if (s === val) return;
      end
      fails++;
      $display("BAD %s exp %b got %b", nm, val, s);
   endtask : wait_sig

   task automatic do_reset(input logic fuse);
      @(posedge i_clk);
      i_rstn <= 1'b0;
      i_safety_level_fuse <= fuse;
      repeat (6) @(posedge i_clk);
      i_rstn <= 1'b1;
      wait_sig(2, 1'b1, 100, "core_rst_n");
   endtask : do_reset

   initial begin
      {i_rstn, i_osc_tick, i_safety_level_fuse, i_restart_instruction, i_irq_ack} = '0;
      {i_global_irq_en, i_pin_rst, i_bod_en, i_bod_low, i_wr, i_rd} = '0;
      i_addr = '0;
      i_wdata = '0;
      {fails, num_checks, cyc, n_rst} = '0;
      do_reset(1'b0);
      rd(A_STATUS, 8'h01, "status por");
      rd(A_CTRL, 8'h00, "ctrl level1");
      rd(2'h2, 8'h00, "unmapped");
      wr(A_STATUS, 8'hff);
      rd(A_STATUS, 8'h01, "status keep");
      wr(A_STATUS, 8'h00);
      rd(A_STATUS, 8'h00, "status clr");
      // enable, refused disable, lapsed window, timed disable
      wr(A_CTRL, 8'h08);
      wr(A_CTRL, 8'h00);
      rd(A_CTRL, 8'h08, "no window");
      wr(A_CTRL, 8'h18);
      repeat (6) @(posedge i_clk);
      rd(A_CTRL, 8'h08, "ce self clr");
      wr(A_CTRL, 8'h00);
      rd(A_CTRL, 8'h08, "late disable");
      wr(A_CTRL, 8'h18);
      wr(A_CTRL, 8'h00);
      rd(A_CTRL, 8'h10, "disabled");
      // every period code; reserved ones leave the last valid code
      last = 8'h00;
      for (int k = 0; k < 16; k++) begin
         wr(A_CTRL, {2'b00, k[3], 2'b00, k[2:0]});
         if (k <= 9) last = {2'b00, k[3], 2'b00, k[2:0]};
         rd(A_CTRL, last, "period code");
      end
      wr(A_CTRL, 8'h00);
      // interrupt mode, cleared by vector then by writing one
      i_global_irq_en <= 1'b1;
      wr(A_CTRL, 8'h40);
      wait_sig(0, 1'b1, 4400, "irq");
      rd(A_CTRL, 8'hc0, "irq flag");
      @(posedge i_clk);
      i_irq_ack <= 1'b1;
      @(posedge i_clk);
      i_irq_ack <= 1'b0;
      rd(A_CTRL, 8'h40, "flag ack");
      wait_sig(0, 1'b1, 4400, "irq 2");
      wr(A_CTRL, 8'hc0);
      rd(A_CTRL, 8'h40, "flag w1c");
      i_global_irq_en <= 1'b0;
      repeat (4400) @(posedge i_clk);
      rd(A_CTRL, 8'hc0, "flag gated");
      chk("irq gated", 8'h00, {7'h00, o_irq});
      wr(A_CTRL, 8'h80);
      // both enables: first time-out interrupts and drops irq enable, second resets
      i_global_irq_en <= 1'b1;
      wr(A_CTRL, 8'h48);
      wait_sig(0, 1'b1, 4400, "irq both");
      rd(A_CTRL, 8'h88, "tie cleared");
      chk("irq held", 8'h01, {7'h00, o_irq});
      wait_sig(1, 1'b1, 4400, "wdt pulse");
      @(posedge i_clk);
      #1;
      chk("pulse width", 8'h00, {6'h00, o_wdt_rst_pulse, o_core_rst_n});
      wait_sig(2, 1'b1, 100, "core_rst_n");
      rd(A_STATUS, 8'h08, "wdog flag");
      rd(A_CTRL, 8'h08, "forced en");
      wr(A_CTRL, 8'h18);
      wr(A_CTRL, 8'h00);
      rd(A_CTRL, 8'h18, "still forced");
      wr(A_STATUS, 8'h00);
      rd(A_CTRL, 8'h00, "flag gone");
      // restarts every 3000 cycles hold off a 4096-cycle time-out
      wr(A_CTRL, 8'h08);
      last = 8'(n_rst);
      repeat (3) begin
         repeat (3000) @(posedge i_clk);
         i_restart_instruction <= 1'b1;
         @(posedge i_clk);
         i_restart_instruction <= 1'b0;
      end
      chk("restart", last, 8'(n_rst));
      wr(A_CTRL, 8'h18);
      wr(A_CTRL, 8'h00);
      // pin and brown-out reset sources
      i_pin_rst <= 1'b1;
      wait_sig(2, 1'b0, 3, "pin rst");
      i_pin_rst <= 1'b0;
      wait_sig(2, 1'b1, 100, "pin rel");
      rd(A_STATUS, 8'h02, "pin flag");
      wr(A_STATUS, 8'h00);
      i_bod_low <= 1'b1;
      repeat (20) @(posedge i_clk);
      #1;
      chk("bod off", 8'h01, {7'h00, o_core_rst_n});
      i_bod_en <= 1'b1;
      wait_sig(2, 1'b0, 2, "bod rst");
      i_bod_low <= 1'b0;
      wait_sig(2, 1'b1, 100, "bod rel");
      rd(A_STATUS, 8'h04, "bod flag");
      // safety level 2: always on, period needs the window
      do_reset(1'b1);
      rd(A_CTRL, 8'h08, "lvl2 en");
      wr(A_CTRL, 8'h18);
      wr(A_CTRL, 8'h00);
      rd(A_CTRL, 8'h18, "lvl2 no off");
      wr(A_CTRL, 8'h09);
      rd(A_CTRL, 8'h08, "lvl2 per");
      wr(A_CTRL, 8'h18);
      wr(A_CTRL, 8'h01);
      rd(A_CTRL, 8'h19, "lvl2 win");
      stop_test();
   end
endmodule : tb_wrf_top
